// File: rtl/pcd_pkg.sv
// Package: constants and rule summary for the port C/D override mux
//
// Function
// - Reset fuse programmed frees bit 6 for I/O
// - Reset-pin mode reads direction, latch, pin zero
// - Two-wire enable makes C5 the clock line
// - Two-wire enable makes C4 the data line
// - Two-wire inputs filtered against spikes under 50ns
// - Two-wire pins open drain, value zero, drive-controlled
// - Two-wire enables pull-up/direction overrides, pull-up from latch
// - Slew control and spike filters when two-wire enabled
// - Port C bits 3..0 never overridden
// - D5 input feeds timer1 count, no overrides
// - D4 feeds usart clock, timer0; sync mode sets output value, direction from port
// - D3/D2 interrupts force input buffer enabled
// - Transmitter forces D1 output, data, pull-up off
// - Receiver forces D0 input, feeds receive data
// - Forced D0 pull-up follows latch and disable
`default_nettype none
package pcd_pkg;
	// ------------------------------------------------------------
	// Pins and timing
	// ------------------------------------------------------------
	localparam int PCD_PORT_W      = 8;
	localparam int PCD_BIT_RESET   = 6;
	localparam int PCD_BIT_SCL     = 5;
	localparam int PCD_BIT_SDA     = 4;
	localparam int PCD_BIT_TXD     = 1;
	localparam int PCD_BIT_RXD     = 0;
	localparam int PCD_BIT_XCK     = 4;
	localparam int PCD_BIT_T1      = 5;
	localparam int PCD_BIT_EXT_INTERRUPT_1    = 3;
	localparam int PCD_BIT_EXT_INTERRUPT_0    = 2;
	localparam int PCD_CLK_PERIOD_NS = 50;
	localparam int PCD_SPIKE_NS      = 50;
	// Least time: rounds up, at least one cycle
	localparam int PCD_SPIKE_CYC_RAW =
		(PCD_SPIKE_NS + PCD_CLK_PERIOD_NS - 1) / PCD_CLK_PERIOD_NS;
	localparam int PCD_SPIKE_CYC = (PCD_SPIKE_CYC_RAW < 1) ? 1 : PCD_SPIKE_CYC_RAW;
	localparam logic [7:0] PCD_RST_BYTE = 8'h00;
endpackage
`default_nettype wire

// File: rtl/pcd_spike_filter.sv
// Module: synchroniser and spike filter for one pin input
`default_nettype none
module pcd_spike_filter #(
	parameter int HOLD = 1
) (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic en,
	input  wire logic pin_in,
	output logic      filt_out
);
	import pcd_pkg::*;
	logic [2:0]  sync_q;
	logic [7:0]  cnt_q;
	// ------------------------------------------------------------
	// Three-stage synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync_q <= 3'h7;
		end else begin
			sync_q <= {sync_q[1:0], pin_in};
		end
	end
	// ------------------------------------------------------------
	// Level must stay stable HOLD cycles
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_q    <= 8'h00;
			filt_out <= 1'b1;
		end else if (sync_q[2] != sync_q[1]) begin
			cnt_q <= 8'h00;
		end else if (!en) begin
			filt_out <= sync_q[2];
			cnt_q    <= 8'h00;
		end else if (sync_q[2] != filt_out) begin
			if (cnt_q >= 8'(HOLD - 1)) begin
				filt_out <= sync_q[2];
				cnt_q    <= 8'h00;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end else begin
			cnt_q <= 8'h00;
		end
	end
	a_filter_holds: assert property (@(posedge mclk) disable iff (!rstn)
		(en && sync_q[2] != sync_q[1]) |=> $stable(filt_out))
		else $error("filter passed an unstable level");
endmodule
`default_nettype wire

// File: rtl/pcd_pin_mux.sv
// Module: alternate function override mux for ports C and D
`default_nettype none
module pcd_pin_mux (
	input  wire logic                         mclk,
	input  wire logic                         rstn,
	input  wire logic                         reset_pin_disable_fuse,
	input  wire logic                         global_pullup_disable,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] portc_latch,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] portc_dir,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] portd_latch,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] portd_dir,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] portc_pad_in,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] portd_pad_in,
	input  wire logic                         two_wire_enable,
	input  wire logic                         scl_drive_low,
	input  wire logic                         sda_drive_low,
	input  wire logic                         usart_sync_mode_select,
	input  wire logic                         usart_clock_out,
	input  wire logic                         transmitter_enable,
	input  wire logic                         transmit_data,
	input  wire logic                         receiver_enable,
	input  wire logic                         ext_interrupt_0_enable,
	input  wire logic                         ext_interrupt_1_enable,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portc_pad_out,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portc_pad_oe,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portc_pullup_en,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portc_in_buf_en,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portd_pad_out,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portd_pad_oe,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portd_pullup_en,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portd_in_buf_en,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portc_pin_read,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portc_dir_read,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portc_latch_read,
	output logic [pcd_pkg::PCD_PORT_W-1:0]    portd_pin_read,
	output logic                              reset_request_n,
	output logic                              slew_limit_en,
	output logic                              scl_in_filtered,
	output logic                              sda_in_filtered,
	output logic                              timer1_count_input,
	output logic                              timer0_count_input,
	output logic                              usart_sync_clock,
	output logic                              ext_interrupt_0,
	output logic                              ext_interrupt_1,
	output logic                              receive_data
);
	import pcd_pkg::*;
	localparam int W = PCD_PORT_W;

	// Override bundles per port
	logic [W-1:0] c_pullup_override_enable, c_pullup_override_value, c_direction_override_enable, c_direction_override_value, c_output_value_override_enable, c_output_value_override_value, c_input_enable_override_enable, c_input_enable_override_value;
	logic [W-1:0] d_pullup_override_enable, d_pullup_override_value, d_direction_override_enable, d_direction_override_value, d_output_value_override_enable, d_output_value_override_value, d_input_enable_override_enable, d_input_enable_override_value;
	logic [W-1:0] c_sync_q, c_sync2_q, c_sync3_q, c_pin_q;
	logic [W-1:0] d_sync_q, d_sync2_q, d_sync3_q, d_pin_q;
	logic         rst_pin;

	assign rst_pin = !reset_pin_disable_fuse;

	// ------------------------------------------------------------
	// Port C override values
	// ------------------------------------------------------------
	always_comb begin
		c_pullup_override_enable  = '0;
		c_pullup_override_value  = '0;
		c_direction_override_enable  = '0;
		c_direction_override_value  = '0;
		c_output_value_override_enable  = '0;
		c_output_value_override_value  = '0;
		c_input_enable_override_enable = '0;
		c_input_enable_override_value = '0;
		// Reset pin takes bit 6 away from the port
		c_pullup_override_enable[PCD_BIT_RESET]  = rst_pin;
		c_pullup_override_value[PCD_BIT_RESET]  = 1'b1;
		c_direction_override_enable[PCD_BIT_RESET]  = rst_pin;
		c_input_enable_override_enable[PCD_BIT_RESET] = rst_pin;
		// Two-wire clock and data lines
		c_pullup_override_enable[PCD_BIT_SCL] = two_wire_enable;
		c_pullup_override_enable[PCD_BIT_SDA] = two_wire_enable;
		c_pullup_override_value[PCD_BIT_SCL] = portc_latch[PCD_BIT_SCL] & !global_pullup_disable;
		c_pullup_override_value[PCD_BIT_SDA] = portc_latch[PCD_BIT_SDA] & !global_pullup_disable;
		c_direction_override_enable[PCD_BIT_SCL] = two_wire_enable;
		c_direction_override_enable[PCD_BIT_SDA] = two_wire_enable;
		c_direction_override_value[PCD_BIT_SCL] = scl_drive_low;
		c_direction_override_value[PCD_BIT_SDA] = sda_drive_low;
		c_output_value_override_enable[PCD_BIT_SCL] = two_wire_enable;
		c_output_value_override_enable[PCD_BIT_SDA] = two_wire_enable;
	end

	// ------------------------------------------------------------
	// Port D override values
	// ------------------------------------------------------------
	always_comb begin
		d_pullup_override_enable  = '0;
		d_pullup_override_value  = '0;
		d_direction_override_enable  = '0;
		d_direction_override_value  = '0;
		d_output_value_override_enable  = '0;
		d_output_value_override_value  = '0;
		d_input_enable_override_enable = '0;
		d_input_enable_override_value = '0;
		d_output_value_override_enable[PCD_BIT_XCK] = usart_sync_mode_select;
		d_output_value_override_value[PCD_BIT_XCK] = usart_clock_out;
		d_input_enable_override_enable[PCD_BIT_EXT_INTERRUPT_1] = ext_interrupt_1_enable;
		d_input_enable_override_value[PCD_BIT_EXT_INTERRUPT_1] = 1'b1;
		d_input_enable_override_enable[PCD_BIT_EXT_INTERRUPT_0] = ext_interrupt_0_enable;
		d_input_enable_override_value[PCD_BIT_EXT_INTERRUPT_0] = 1'b1;
		d_pullup_override_enable[PCD_BIT_TXD] = transmitter_enable;
		d_direction_override_enable[PCD_BIT_TXD] = transmitter_enable;
		d_direction_override_value[PCD_BIT_TXD] = 1'b1;
		d_output_value_override_enable[PCD_BIT_TXD] = transmitter_enable;
		d_output_value_override_value[PCD_BIT_TXD] = transmit_data;
		d_pullup_override_enable[PCD_BIT_RXD] = receiver_enable;
		d_direction_override_enable[PCD_BIT_RXD] = receiver_enable;
		d_pullup_override_value[PCD_BIT_RXD] = portd_latch[PCD_BIT_RXD] & !global_pullup_disable;
	end

	// ------------------------------------------------------------
	// Generic pin logic: override replaces port control
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < W; i++) begin
			portc_pad_oe[i]    = c_direction_override_enable[i] ? c_direction_override_value[i] : portc_dir[i];
			portc_pad_out[i]   = c_output_value_override_enable[i] ? c_output_value_override_value[i] : portc_latch[i];
			portc_pullup_en[i] = c_pullup_override_enable[i] ? c_pullup_override_value[i]
				: (portc_latch[i] & !portc_dir[i] & !global_pullup_disable);
			portc_in_buf_en[i] = c_input_enable_override_enable[i] ? c_input_enable_override_value[i] : 1'b1;
			portd_pad_oe[i]    = d_direction_override_enable[i] ? d_direction_override_value[i] : portd_dir[i];
			portd_pad_out[i]   = d_output_value_override_enable[i] ? d_output_value_override_value[i] : portd_latch[i];
			portd_pullup_en[i] = d_pullup_override_enable[i] ? d_pullup_override_value[i]
				: (portd_latch[i] & !portd_dir[i] & !global_pullup_disable);
			portd_in_buf_en[i] = d_input_enable_override_enable[i] ? d_input_enable_override_value[i] : 1'b1;
		end
		// Reset pin keeps its pull-up for the reset circuit
		portc_pullup_en[PCD_BIT_RESET] = c_pullup_override_enable[PCD_BIT_RESET] ? 1'b1
			: (portc_latch[PCD_BIT_RESET] & !portc_dir[PCD_BIT_RESET]
			& !global_pullup_disable);
	end

	// ------------------------------------------------------------
	// Pin input synchronisers (change counts when stages 2 and 3 agree)
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			c_sync_q  <= PCD_RST_BYTE;
			c_sync2_q <= PCD_RST_BYTE;
			c_sync3_q <= PCD_RST_BYTE;
			d_sync_q  <= PCD_RST_BYTE;
			d_sync2_q <= PCD_RST_BYTE;
			d_sync3_q <= PCD_RST_BYTE;
		end else begin
			c_sync_q  <= portc_pad_in & portc_in_buf_en;
			c_sync2_q <= c_sync_q;
			c_sync3_q <= c_sync2_q;
			d_sync_q  <= portd_pad_in & portd_in_buf_en;
			d_sync2_q <= d_sync_q;
			d_sync3_q <= d_sync2_q;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			c_pin_q <= PCD_RST_BYTE;
			d_pin_q <= PCD_RST_BYTE;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (c_sync2_q[i] == c_sync3_q[i]) begin
					c_pin_q[i] <= c_sync3_q[i];
				end
				if (d_sync2_q[i] == d_sync3_q[i]) begin
					d_pin_q[i] <= d_sync3_q[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Register read view and peripheral inputs
	// ------------------------------------------------------------
	always_comb begin
		portc_pin_read   = c_pin_q;
		portc_dir_read   = portc_dir;
		portc_latch_read = portc_latch;
		portc_pin_read[W-1]   = 1'b0;
		portc_dir_read[W-1]   = 1'b0;
		portc_latch_read[W-1] = 1'b0;
		if (rst_pin) begin
			portc_pin_read[PCD_BIT_RESET]   = 1'b0;
			portc_dir_read[PCD_BIT_RESET]   = 1'b0;
			portc_latch_read[PCD_BIT_RESET] = 1'b0;
		end
	end

	assign portd_pin_read     = d_pin_q;
	assign reset_request_n    = rst_pin ? portc_pad_in[PCD_BIT_RESET] : 1'b1;
	assign slew_limit_en      = two_wire_enable;
	assign timer1_count_input = d_pin_q[PCD_BIT_T1];
	assign timer0_count_input = d_pin_q[PCD_BIT_XCK];
	assign usart_sync_clock   = d_pin_q[PCD_BIT_XCK];
	assign ext_interrupt_1    = d_pin_q[PCD_BIT_EXT_INTERRUPT_1];
	assign ext_interrupt_0    = d_pin_q[PCD_BIT_EXT_INTERRUPT_0];
	assign receive_data       = d_pin_q[PCD_BIT_RXD];

	// Spike filters on the two-wire lines
	pcd_spike_filter #(.HOLD(PCD_SPIKE_CYC)) u_scl_filt (
		.mclk     (mclk),
		.rstn     (rstn),
		.en       (two_wire_enable),
		.pin_in   (portc_pad_in[PCD_BIT_SCL]),
		.filt_out (scl_in_filtered)
	);
	pcd_spike_filter #(.HOLD(PCD_SPIKE_CYC)) u_sda_filt (
		.mclk     (mclk),
		.rstn     (rstn),
		.en       (two_wire_enable),
		.pin_in   (portc_pad_in[PCD_BIT_SDA]),
		.filt_out (sda_in_filtered)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Receive pin rise has passed both agreeing stages
	sequence s_rx_agreed;
		$rose(d_sync3_q[0]) && d_sync2_q[0];
	endsequence

	a_reset_reads_zero: assert property (@(posedge mclk) disable iff (!rstn)
		rst_pin |-> (portc_dir_read[6] | portc_latch_read[6] | portc_pin_read[6]) == 1'b0)
		else $error("reset pin bits not read as zero");
	a_reset_pin_off: assert property (@(posedge mclk) disable iff (!rstn)
		rst_pin |-> !portc_pad_oe[PCD_BIT_RESET] && portc_in_buf_en[PCD_BIT_RESET] == 1'b0)
		else $error("reset pin still acts as I/O");
	a_twi_open_drain: assert property (@(posedge mclk) disable iff (!rstn)
		two_wire_enable |-> portc_pad_out[5:4] == 2'b00
		&& portc_pad_oe[5:4] == {scl_drive_low, sda_drive_low})
		else $error("two-wire pins not open drain");
	a_twi_pullup: assert property (@(posedge mclk) disable iff (!rstn)
		two_wire_enable |-> portc_pullup_en[5:4]
		== (portc_latch[5:4] & {2{!global_pullup_disable}}))
		else $error("two-wire pull-up wrong");
	a_low_c_plain: assert property (@(posedge mclk) disable iff (!rstn)
		portc_pad_oe[3:0] == portc_dir[3:0] && portc_pad_out[3:0] == portc_latch[3:0])
		else $error("port C low bits overridden");
	a_tx_forced: assert property (@(posedge mclk) disable iff (!rstn)
		transmitter_enable |-> portd_pad_oe[1] && portd_pad_out[1] == transmit_data
		&& !portd_pullup_en[1])
		else $error("transmit pin not forced");
	a_rx_forced: assert property (@(posedge mclk) disable iff (!rstn)
		receiver_enable |-> !portd_pad_oe[0]
		&& portd_pullup_en[0] == (portd_latch[0] & !global_pullup_disable))
		else $error("receive pin not forced input");
	a_int_buffer: assert property (@(posedge mclk) disable iff (!rstn)
		(ext_interrupt_0_enable |-> portd_in_buf_en[2])
		and (ext_interrupt_1_enable |-> portd_in_buf_en[3]))
		else $error("interrupt pin buffer disabled");
	a_xck_drive: assert property (@(posedge mclk) disable iff (!rstn)
		usart_sync_mode_select |-> portd_pad_out[4] == usart_clock_out)
		else $error("sync clock not driven");
	a_rx_latency: assert property (@(posedge mclk) disable iff (!rstn)
		s_rx_agreed |=> receive_data)
		else $error("receive data not delivered");
endmodule
`default_nettype wire

// File: verif/pcd_pad_model.sv
// Pad model: resolves pin levels from the mux drive and the external parties
`default_nettype none
module pcd_pad_model (
	input  wire logic                           mclk,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] drv_val,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] drv_en,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] pu_en,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] ext_val,
	input  wire logic [pcd_pkg::PCD_PORT_W-1:0] ext_en,
	output logic      [pcd_pkg::PCD_PORT_W-1:0] pad
);
	timeunit 1ns;
	timeprecision 1ns;
	import pcd_pkg::*;
	logic tgl_q = 1'b0;
	// Floating pins wander instead of holding a stale level
	always @(posedge mclk) begin
		tgl_q <= ~tgl_q;
	end
	// Mux drive wins, so an open-drain low overpowers the external pull
	always_comb begin
		for (int i = 0; i < PCD_PORT_W; i++) begin
			pad[i] = drv_en[i] ? drv_val[i] : ext_en[i] ? ext_val[i] : pu_en[i] ? 1'b1 : tgl_q;
		end
	end
endmodule
`default_nettype wire

// File: verif/pcd_pin_mux_tb.sv
// Testbench for the port C/D override mux
`default_nettype none
module pcd_pin_mux_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pcd_pkg::*;
	logic mclk, rstn, reset_pin_disable_fuse, global_pullup_disable, two_wire_enable;
	logic scl_drive_low, sda_drive_low, usart_sync_mode_select, usart_clock_out;
	logic transmitter_enable, transmit_data, receiver_enable;
	logic ext_interrupt_0_enable, ext_interrupt_1_enable, reset_request_n, slew_limit_en;
	logic scl_in_filtered, sda_in_filtered, timer1_count_input, timer0_count_input;
	logic usart_sync_clock, ext_interrupt_0, ext_interrupt_1, receive_data;
	logic [PCD_PORT_W-1:0] portc_latch, portc_dir, portd_latch, portd_dir, portc_pad_in;
	logic [PCD_PORT_W-1:0] portd_pad_in, portc_pad_out, portc_pad_oe, portc_pullup_en;
	logic [PCD_PORT_W-1:0] portc_in_buf_en, portd_pad_out, portd_pad_oe, portd_pullup_en;
	logic [PCD_PORT_W-1:0] portd_in_buf_en, portc_pin_read, portc_dir_read;
	logic [PCD_PORT_W-1:0] portc_latch_read, portd_pin_read, c_ev, d_ev;
	logic [7:0]            obs;
	int err_total = 0;
	int n_tests = 0;

	pcd_pin_mux u_dut (
		.mclk                   (mclk),
		.rstn                   (rstn),
		.reset_pin_disable_fuse (reset_pin_disable_fuse),
		.global_pullup_disable  (global_pullup_disable),
		.portc_latch            (portc_latch),
		.portc_dir              (portc_dir),
		.portd_latch            (portd_latch),
		.portd_dir              (portd_dir),
		.portc_pad_in           (portc_pad_in),
		.portd_pad_in           (portd_pad_in),
		.two_wire_enable        (two_wire_enable),
		.scl_drive_low          (scl_drive_low),
		.sda_drive_low          (sda_drive_low),
		.usart_sync_mode_select (usart_sync_mode_select),
		.usart_clock_out        (usart_clock_out),
		.transmitter_enable     (transmitter_enable),
		.transmit_data          (transmit_data),
		.receiver_enable        (receiver_enable),
		.ext_interrupt_0_enable (ext_interrupt_0_enable),
		.ext_interrupt_1_enable (ext_interrupt_1_enable),
		.portc_pad_out          (portc_pad_out),
		.portc_pad_oe           (portc_pad_oe),
		.portc_pullup_en        (portc_pullup_en),
		.portc_in_buf_en        (portc_in_buf_en),
		.portd_pad_out          (portd_pad_out),
		.portd_pad_oe           (portd_pad_oe),
		.portd_pullup_en        (portd_pullup_en),
		.portd_in_buf_en        (portd_in_buf_en),
		.portc_pin_read         (portc_pin_read),
		.portc_dir_read         (portc_dir_read),
		.portc_latch_read       (portc_latch_read),
		.portd_pin_read         (portd_pin_read),
		.reset_request_n        (reset_request_n),
		.slew_limit_en          (slew_limit_en),
		.scl_in_filtered        (scl_in_filtered),
		.sda_in_filtered        (sda_in_filtered),
		.timer1_count_input     (timer1_count_input),
		.timer0_count_input     (timer0_count_input),
		.usart_sync_clock       (usart_sync_clock),
		.ext_interrupt_0        (ext_interrupt_0),
		.ext_interrupt_1        (ext_interrupt_1),
		.receive_data           (receive_data)
	);
	pcd_pad_model u_padc (.mclk(mclk), .drv_val(portc_pad_out), .drv_en(portc_pad_oe),
		.pu_en(portc_pullup_en), .ext_val(c_ev), .ext_en(8'hff), .pad(portc_pad_in));
	pcd_pad_model u_padd (.mclk(mclk), .drv_val(portd_pad_out), .drv_en(portd_pad_oe),
		.pu_en(portd_pullup_en), .ext_val(d_ev), .ext_en(8'hff), .pad(portd_pad_in));

	// Watched single-bit outputs, selected by index in wait1
	assign obs = {ext_interrupt_0, ext_interrupt_1, usart_sync_clock, timer0_count_input,
		timer1_count_input, receive_data, sda_in_filtered, scl_in_filtered};

	always #25 mclk = ~mclk;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic step();
		@(posedge mclk);
		#5;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait1(input string what, input int sel, input logic exp);
		for (int k = 0; k < 12 && obs[sel] !== exp; k++) step();
		chk(what, {7'h00, exp}, {7'h00, obs[sel]});
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_pin();
		reset_pin_disable_fuse = 1'b0;
		portc_dir = 8'h40;
		portc_latch = 8'h40;
		c_ev = 8'h70;
		repeat (6) step();
		chk("dir read", 8'h00, portc_dir_read);
		chk("latch read", 8'h00, portc_latch_read);
		chk("pin read", 8'h00, portc_pin_read & 8'h40);
		chk("c6 in buf", 8'h00, portc_in_buf_en & 8'h40);
		chk("c6 oe", 8'h00, portc_pad_oe & 8'h40);
		chk("reset high", 8'h01, {7'h00, reset_request_n});
		c_ev = 8'h30;
		step();
		chk("reset low", 8'h00, {7'h00, reset_request_n});
		reset_pin_disable_fuse = 1'b1;
		repeat (6) step();
		chk("dir io", 8'h40, portc_dir_read);
		chk("pin io", 8'h40, portc_pin_read & 8'h40);
		chk("c6 oe io", 8'h40, portc_pad_oe & 8'h40);
		chk("reset idle", 8'h01, {7'h00, reset_request_n});
		$display("Done reset pin");
	endtask

	task automatic t_two_wire();
		logic bad;
		bad = 1'b0;
		two_wire_enable = 1'b1;
		portc_latch = 8'h35;
		portc_dir = 8'h13;
		scl_drive_low = 1'b1;
		step();
		chk("c out", 8'h05, portc_pad_out & 8'h3f);
		chk("c oe", 8'h23, portc_pad_oe & 8'h3f);
		chk("c pullup", 8'h04, portc_pullup_en & 8'h0f);
		chk("twi pullup", 8'h30, portc_pullup_en & 8'h30);
		chk("slew", 8'h01, {7'h00, slew_limit_en});
		wait1("scl low", 0, 1'b0);
		sda_drive_low = 1'b1;
		scl_drive_low = 1'b0;
		wait1("sda low", 1, 1'b0);
		wait1("scl high", 0, 1'b1);
		sda_drive_low = 1'b0;
		wait1("sda high", 1, 1'b1);
		#20 c_ev = 8'h20;
		@(posedge mclk);
		#20 c_ev = 8'h30;
		repeat (10) begin
			step();
			if (sda_in_filtered !== 1'b1) bad = 1'b1;
		end
		chk("spike", 8'h00, {7'h00, bad});
		$display("Done two wire");
	endtask

	task automatic t_usart();
		portd_latch = 8'h83;
		portd_dir = 8'h81;
		transmitter_enable = 1'b1;
		transmit_data = 1'b1;
		receiver_enable = 1'b1;
		usart_sync_mode_select = 1'b1;
		usart_clock_out = 1'b1;
		step();
		chk("d oe", 8'h82, portd_pad_oe & 8'hd3);
		chk("d out", 8'h93, portd_pad_out & 8'h93);
		chk("d pullup", 8'h01, portd_pullup_en & 8'hc3);
		transmit_data = 1'b0;
		global_pullup_disable = 1'b1;
		step();
		chk("tx data", 8'h00, portd_pad_out & 8'h02);
		chk("rx pullup", 8'h00, portd_pullup_en & 8'h01);
		portd_latch = 8'h80;
		d_ev = 8'h31;
		wait1("rx data", 2, 1'b1);
		wait1("timer1", 3, 1'b1);
		wait1("timer0", 4, 1'b1);
		wait1("sync clk", 5, 1'b1);
		chk("d pins", 8'h31, portd_pin_read & 8'h31);
		$display("Done usart");
	endtask

	task automatic t_ints();
		ext_interrupt_0_enable = 1'b1;
		ext_interrupt_1_enable = 1'b1;
		global_pullup_disable = 1'b0;
		portd_dir = 8'h00;
		portd_latch = 8'h00;
		step();
		chk("in buf", 8'h0c, portd_in_buf_en & 8'h0c);
		chk("cmp pins", 8'h00, (portd_pad_oe | portd_pullup_en) & 8'hc0);
		d_ev = 8'h08;
		wait1("ext_interrupt_1", 6, 1'b1);
		d_ev = 8'h04;
		wait1("ext_interrupt_0", 7, 1'b1);
		wait1("ext_interrupt_1 low", 6, 1'b0);
		$display("Done interrupts");
	endtask

	initial begin
		{mclk, rstn, global_pullup_disable, two_wire_enable, scl_drive_low} = 5'h00;
		{sda_drive_low, usart_sync_mode_select, usart_clock_out} = 3'h0;
		{transmitter_enable, transmit_data, receiver_enable} = 3'h0;
		{ext_interrupt_0_enable, ext_interrupt_1_enable} = 2'h0;
		reset_pin_disable_fuse = 1'b1;
		{portc_latch, portc_dir, portd_latch, portd_dir, d_ev} = 40'h00_0000_0000;
		c_ev = 8'h30;
		repeat (4) @(posedge mclk);
		#5 rstn = 1'b1;
		step();
		t_reset_pin();
		t_two_wire();
		t_usart();
		t_ints();
		tally_and_finish();
	end

	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
